// ===== hw/dpc_pkg.sv
// Purpose: shared constants for the downstream port configuration registers
// Assumes: byte-wide register port, four downstream ports
// Notes: offsets are the register addresses seen on the register port
package dpc_pkg;
  // port count and data width
  localparam int unsigned DPC_PORTS = 4;
  localparam int unsigned DPC_DATA_W = 8;
  localparam int unsigned DPC_ADDR_W = 8;
  // register offsets
  localparam logic [7:0] DPC_ADDR_CHARGE = 8'h06;
  localparam logic [7:0] DPC_ADDR_REMOVABLE = 8'h07;
  localparam logic [7:0] DPC_ADDR_USED = 8'h08;
  // field layout
  localparam int unsigned DPC_OVR_BIT = 7;
  localparam int unsigned DPC_FIELD_LSB = 0;
  localparam int unsigned DPC_FIELD_MSB = 3;
  // reset and fill values
  localparam logic [3:0] DPC_FIELD_RST = 4'h0;
  localparam logic [3:0] DPC_USED_RST = 4'hF;
  localparam logic [3:0] DPC_RSVD4_ZERO = 4'h0;
  localparam logic [2:0] DPC_RSVD3_ZERO = 3'h0;
  localparam logic [7:0] DPC_UNMAPPED_DATA = 8'h00;
  localparam logic DPC_OVR_RST = 1'h0;
  // edges after reset release until the synchronised straps are valid
  localparam logic [1:0] DPC_STRAP_SETTLE = 2'h2;
  localparam logic [1:0] DPC_SETTLE_STEP = 2'h1;
endpackage

// ===== hw/dpc_field.sv
// Purpose: one four-bit configuration field with a gated write and a preload
// Assumes: preload and write never both needed in one cycle; preload wins
// Notes: a write whose allow term is low leaves the field untouched
module dpc_field #(
  parameter int unsigned W = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // preload from straps
  input wire logic load,
  input wire logic [W-1:0] load_val,
  // register write
  input wire logic wr_en,
  input wire logic allow,
  input wire logic [W-1:0] wdata,
  // stored value
  output logic [W-1:0] q
);
  logic [W-1:0] field_q;
  logic [W-1:0] field_d;

  always_comb begin
    field_d = field_q;
    if (load) begin
      field_d = load_val;
    end else if (wr_en && allow) begin
      field_d = wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      field_q <= RST_VAL;
    end else begin
      field_q <= field_d;
    end
  end

  assign q = field_q;
endmodule

// ===== hw/dpc_regs.sv
// Purpose: downstream port configuration registers of a four-port hub
// Assumes: one register port shared by the eeprom loader and the serial host
// Notes: all outputs are registered, one cycle behind the stored state
// Operation
// - charge enables per port, bit 0 port 1; strap default; serial-bus writable
// - reserved upper bits of charge and removable registers read zero
// - override clear: removable, used, usb2-only read-only from one-time memory
// - override set: removable, used, usb2-only become writable
// - one write may set override and new removable value together
// - removable bit n set means device on port n+1 is removable
// - override clear: removable reads inverse of stored non-removable bits
// - used bit set enables port, bit 0 port 1; read-only without override
// - after reset used register holds four used bits set, upper clear
// - usb2-only set forces that port's usb2 side used regardless of used bit
module dpc_regs (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // strap and mode pins
  input wire logic [dpc_pkg::DPC_PORTS-1:0] power_charge_strap,
  input wire logic serial_bus_mode,
  // one-time memory contents
  input wire logic [dpc_pkg::DPC_PORTS-1:0] otp_non_removable,
  input wire logic [dpc_pkg::DPC_PORTS-1:0] otp_port_used,
  input wire logic [dpc_pkg::DPC_PORTS-1:0] otp_legacy_speed_only,
  // register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [dpc_pkg::DPC_ADDR_W-1:0] reg_addr,
  input wire logic [dpc_pkg::DPC_DATA_W-1:0] reg_wdata,
  output logic [dpc_pkg::DPC_DATA_W-1:0] reg_rdata,
  output logic reg_rd_valid,
  // usb2-only field write
  input wire logic lso_wr_en,
  input wire logic [dpc_pkg::DPC_PORTS-1:0] lso_wdata,
  // configuration outputs
  output logic [dpc_pkg::DPC_PORTS-1:0] charge_port_enable,
  output logic custom_port_override,
  output logic [dpc_pkg::DPC_PORTS-1:0] port_removable,
  output logic [dpc_pkg::DPC_PORTS-1:0] port_used,
  output logic [dpc_pkg::DPC_PORTS-1:0] legacy_speed_only,
  output logic [dpc_pkg::DPC_PORTS-1:0] port_usb2_used
);
  import dpc_pkg::*;

  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [DPC_PORTS-1:0] strap_meta_q;
  logic [DPC_PORTS-1:0] strap_q;
  logic mode_meta_q;
  logic mode_q;
  logic [1:0] settle_q;
  logic strap_done_q;
  logic strap_load;
  logic wr_charge;
  logic wr_rmbl;
  logic wr_used;
  logic override_q;
  logic [DPC_PORTS-1:0] charge_q;
  logic [DPC_PORTS-1:0] rmbl_q;
  logic [DPC_PORTS-1:0] used_q;
  logic [DPC_PORTS-1:0] lso_q;
  logic [DPC_PORTS-1:0] rmbl_eff;
  logic [DPC_PORTS-1:0] used_eff;
  logic [DPC_PORTS-1:0] lso_eff;
  logic [DPC_DATA_W-1:0] rd_mux;
  logic [DPC_DATA_W-1:0] rdata_q;
  logic rd_valid_q;
  logic [DPC_PORTS-1:0] charge_out_q;
  logic ovr_out_q;
  logic [DPC_PORTS-1:0] rmbl_out_q;
  logic [DPC_PORTS-1:0] used_out_q;
  logic [DPC_PORTS-1:0] lso_out_q;
  logic [DPC_PORTS-1:0] usb2_out_q;
  logic post_rst_q;

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'h1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // pin synchronisers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_meta_q <= DPC_FIELD_RST;
      strap_q <= DPC_FIELD_RST;
      mode_meta_q <= 1'h0;
      mode_q <= 1'h0;
    end else begin
      strap_meta_q <= power_charge_strap;
      strap_q <= strap_meta_q;
      mode_meta_q <= serial_bus_mode;
      mode_q <= mode_meta_q;
    end
  end

  // wait for the strap pipeline to fill, then take the straps once
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_q <= 2'h0;
      strap_done_q <= 1'h0;
    end else begin
      if (settle_q != DPC_STRAP_SETTLE) begin
        settle_q <= settle_q + DPC_SETTLE_STEP;
      end
      if (strap_load) begin
        strap_done_q <= 1'h1;
      end
    end
  end
  assign strap_load = (settle_q == DPC_STRAP_SETTLE) && !strap_done_q;

  // address decode
  assign wr_charge = reg_wr_en && (reg_addr == DPC_ADDR_CHARGE);
  assign wr_rmbl = reg_wr_en && (reg_addr == DPC_ADDR_REMOVABLE);
  assign wr_used = reg_wr_en && (reg_addr == DPC_ADDR_USED);

  // override bit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      override_q <= DPC_OVR_RST;
    end else if (wr_rmbl) begin
      override_q <= reg_wdata[DPC_OVR_BIT];
    end
  end

  // charge enables: writable only in serial-bus mode
  dpc_field #(.W(DPC_PORTS), .RST_VAL(DPC_FIELD_RST)) u_charge (
    .clk(sys_clk),
    .rst_n(rst_n),
    .load(strap_load),
    .load_val(strap_q),
    .wr_en(wr_charge),
    .allow(mode_q),
    .wdata(reg_wdata[DPC_FIELD_MSB:DPC_FIELD_LSB]),
    .q(charge_q)
  );

  // removable: allowed by the override value carried in the same write
  dpc_field #(.W(DPC_PORTS), .RST_VAL(DPC_FIELD_RST)) u_rmbl (
    .clk(sys_clk),
    .rst_n(rst_n),
    .load(1'h0),
    .load_val(DPC_FIELD_RST),
    .wr_en(wr_rmbl),
    .allow(reg_wdata[DPC_OVR_BIT]),
    .wdata(reg_wdata[DPC_FIELD_MSB:DPC_FIELD_LSB]),
    .q(rmbl_q)
  );

  dpc_field #(.W(DPC_PORTS), .RST_VAL(DPC_USED_RST)) u_used (
    .clk(sys_clk),
    .rst_n(rst_n),
    .load(1'h0),
    .load_val(DPC_FIELD_RST),
    .wr_en(wr_used),
    .allow(override_q),
    .wdata(reg_wdata[DPC_FIELD_MSB:DPC_FIELD_LSB]),
    .q(used_q)
  );

  dpc_field #(.W(DPC_PORTS), .RST_VAL(DPC_FIELD_RST)) u_lso (
    .clk(sys_clk),
    .rst_n(rst_n),
    .load(1'h0),
    .load_val(DPC_FIELD_RST),
    .wr_en(lso_wr_en),
    .allow(override_q),
    .wdata(lso_wdata),
    .q(lso_q)
  );

  // values in force: one-time memory unless overridden
  assign rmbl_eff = override_q ? rmbl_q : ~otp_non_removable;
  assign used_eff = override_q ? used_q : otp_port_used;
  assign lso_eff = override_q ? lso_q : otp_legacy_speed_only;

  // read mux, unmapped offsets read zero
  always_comb begin
    case (reg_addr)
      DPC_ADDR_CHARGE: rd_mux = {DPC_RSVD4_ZERO, charge_q};
      DPC_ADDR_REMOVABLE: rd_mux = {override_q, DPC_RSVD3_ZERO, rmbl_eff};
      DPC_ADDR_USED: rd_mux = {DPC_RSVD4_ZERO, used_eff};
      default: rd_mux = DPC_UNMAPPED_DATA;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= DPC_UNMAPPED_DATA;
      rd_valid_q <= 1'h0;
    end else begin
      rd_valid_q <= reg_rd_en;
      if (reg_rd_en) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // registered configuration outputs
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      charge_out_q <= DPC_FIELD_RST;
      ovr_out_q <= DPC_OVR_RST;
      rmbl_out_q <= DPC_FIELD_RST;
      used_out_q <= DPC_USED_RST;
      lso_out_q <= DPC_FIELD_RST;
      usb2_out_q <= DPC_USED_RST;
    end else begin
      charge_out_q <= charge_q;
      ovr_out_q <= override_q;
      rmbl_out_q <= rmbl_eff;
      used_out_q <= used_eff;
      lso_out_q <= lso_eff;
      usb2_out_q <= used_eff | lso_eff;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rd_valid = rd_valid_q;
  assign charge_port_enable = charge_out_q;
  assign custom_port_override = ovr_out_q;
  assign port_removable = rmbl_out_q;
  assign port_used = used_out_q;
  assign legacy_speed_only = lso_out_q;
  assign port_usb2_used = usb2_out_q;

  // helper: high in the first cycle after reset release
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      post_rst_q <= 1'h1;
    end else begin
      post_rst_q <= 1'h0;
    end
  end

  default clocking dpc_cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  AST_STRAP_TAKEN: assert property (
    strap_load |=> (charge_q == $past(strap_q)) ##1 (charge_port_enable == $past(strap_q, 2))
  ) else $error("charge enables not taken from straps");

  AST_CHARGE_WRITE: assert property (
    (wr_charge && mode_q && !strap_load) |=> charge_q == $past(reg_wdata[DPC_FIELD_MSB:0])
  ) else $error("charge enable write lost in serial-bus mode");

  AST_CHARGE_RSVD: assert property (
    (reg_rd_en && reg_addr == DPC_ADDR_CHARGE) |=> reg_rd_valid && reg_rdata[7:4] == DPC_RSVD4_ZERO
  ) else $error("charge register reserved bits not zero");

  AST_RMBL_RSVD: assert property (
    (reg_rd_en && reg_addr == DPC_ADDR_REMOVABLE) |=> reg_rdata[6:4] == DPC_RSVD3_ZERO
  ) else $error("removable register reserved bits not zero");

  AST_RMBL_RO: assert property (
    (wr_rmbl && !reg_wdata[DPC_OVR_BIT]) |=> rmbl_q == $past(rmbl_q)
  ) else $error("removable field changed without override");

  AST_LSO_WRITE: assert property (
    (override_q && lso_wr_en) |=> lso_q == $past(lso_wdata) ##1 legacy_speed_only == $past(lso_wdata, 2)
  ) else $error("usb2-only write not applied under override");

  AST_SAME_WRITE: assert property (
    (wr_rmbl && reg_wdata[DPC_OVR_BIT]) |=> override_q && rmbl_q == $past(reg_wdata[3:0])
      ##1 custom_port_override && port_removable == $past(reg_wdata[3:0], 2)
  ) else $error("override and removable value not taken together");

  AST_RMBL_VIEW: assert property (
    override_q |=> port_removable == $past(rmbl_q)
  ) else $error("removable output differs from stored field");

  AST_OTP_INVERT: assert property (
    !override_q |=> port_removable == ~$past(otp_non_removable)
  ) else $error("removable output not inverse of one-time memory");

  AST_USED_OTP: assert property (
    !override_q |=> port_used == $past(otp_port_used)
  ) else $error("used output not from one-time memory");

  AST_USED_RESET: assert property (
    post_rst_q |-> used_q == DPC_USED_RST && !override_q
  ) else $error("used register not at reset value");

  AST_USB2_FORCE: assert property (
    (legacy_speed_only & ~port_usb2_used) == DPC_FIELD_RST
  ) else $error("usb2-only port not marked used");

  AST_USED_IGNORED: assert property (
    (wr_used && !override_q) |=> used_q == $past(used_q)
  ) else $error("read-only used field was written");

  AST_CHARGE_IGNORED: assert property (
    (wr_charge && !mode_q && !strap_load) |=> charge_q == $past(charge_q)
  ) else $error("charge enables written outside serial-bus mode");

  COV_STRAP: cover property (strap_load ##1 charge_q != DPC_FIELD_RST);
  COV_SAME_WRITE: cover property (wr_rmbl && reg_wdata[DPC_OVR_BIT] && !override_q);
  COV_USED_WRITE: cover property (wr_used && override_q ##1 used_q != DPC_USED_RST);
  COV_FORCE: cover property (legacy_speed_only != DPC_FIELD_RST && port_used != DPC_USED_RST);
endmodule

// ===== sim/dpc_host_model.sv
// Purpose: serial host or eeprom loader model driving the register port
// Assumes: one-cycle strobes, changed 1 ns after the rising edge
// Notes: released address and data show the inverse of the last value
module dpc_host_model (
  // clock
  input wire logic sys_clk,
  // register port
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [dpc_pkg::DPC_ADDR_W-1:0] reg_addr,
  output logic [dpc_pkg::DPC_DATA_W-1:0] reg_wdata,
  input wire logic [dpc_pkg::DPC_DATA_W-1:0] reg_rdata,
  input wire logic reg_rd_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h5A;
    reg_wdata = 8'hA5;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_wr_en = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // bounded wait for the read answer
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_rd_en = 1'b0;
    reg_addr = ~a;
    for (int n = 0; n < 3 && reg_rd_valid !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    d = (reg_rd_valid === 1'b1) ? reg_rdata : 'x;
  endtask
endmodule

// ===== sim/dpc_regs_bench.sv
// Purpose: self-checking bench for the port configuration registers
// Assumes: fixed seed, register port driven through the host model
// Notes: expected values come from a shadow copy of the fields
module dpc_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import dpc_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic sbm = 1'b0;
  logic lso_wr_en = 1'b0;
  logic [3:0] strap, otp_nr, otp_used, otp_lso, lso_wdata;
  logic reg_wr_en, reg_rd_en, reg_rd_valid, ovr, e_ovr;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] chg, rem, used, lso, usb2, e_chg, e_rem, e_used, e_lso;
  logic [31:0] r;
  int mismatches = 0;
  int tests_run = 0;
  int seed = 88722;
  int cycles = 0;
  always #2.5 sys_clk = ~sys_clk;
  dpc_regs uut (.sys_clk(sys_clk), .resetn(resetn), .power_charge_strap(strap),
    .serial_bus_mode(sbm), .otp_non_removable(otp_nr), .otp_port_used(otp_used),
    .otp_legacy_speed_only(otp_lso), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .lso_wr_en(lso_wr_en), .lso_wdata(lso_wdata),
    .charge_port_enable(chg), .custom_port_override(ovr), .port_removable(rem),
    .port_used(used), .legacy_speed_only(lso), .port_usb2_used(usb2));
  dpc_host_model host (.sys_clk(sys_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid));
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cmp4(input string n, input logic [3:0] e, input logic [3:0] s);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    case (a)
      DPC_ADDR_CHARGE: return {4'h0, e_chg};
      DPC_ADDR_REMOVABLE: return {e_ovr, 3'h0, e_ovr ? e_rem : ~otp_nr};
      DPC_ADDR_USED: return {4'h0, e_ovr ? e_used : otp_used};
      default: return 8'h00;
    endcase
  endfunction
  task automatic check_all();
    logic [7:0] d;
    logic [3:0] ue;
    logic [3:0] le;
    repeat (3) @(posedge sys_clk);
    #1;
    ue = e_ovr ? e_used : otp_used;
    le = e_ovr ? e_lso : otp_lso;
    cmp4("charge_port_enable", e_chg, chg);
    cmp4("custom_port_override", {3'h0, e_ovr}, {3'h0, ovr});
    cmp4("port_removable", e_ovr ? e_rem : ~otp_nr, rem);
    cmp4("port_used", ue, used);
    cmp4("legacy_speed_only", le, lso);
    cmp4("port_usb2_used", ue | le, usb2);
    for (int i = 6; i < 10; i++) begin
      host.rd(i[7:0], d);
      cmp8("reg_rdata", exp_rd(i[7:0]), d);
    end
  endtask
  task automatic do_wr(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    if (a == DPC_ADDR_CHARGE && sbm) e_chg = d[3:0];
    if (a == DPC_ADDR_USED && e_ovr) e_used = d[3:0];
    if (a == DPC_ADDR_REMOVABLE) begin
      if (d[7]) e_rem = d[3:0];
      e_ovr = d[7];
    end
  endtask
  task automatic do_lso(input logic [3:0] d);
    @(posedge sys_clk);
    #1;
    lso_wdata = d;
    lso_wr_en = 1'b1;
    @(posedge sys_clk);
    #1;
    lso_wr_en = 1'b0;
    if (e_ovr) e_lso = d;
  endtask
  initial begin
    r = $random(seed);
    strap = r[3:0];
    otp_nr = r[7:4];
    otp_used = r[11:8];
    otp_lso = r[15:12];
    lso_wdata = 4'h0;
    repeat (5) @(posedge sys_clk);
    #1;
    cmp4("port_used", 4'hF, used);
    cmp4("port_usb2_used", 4'hF, usb2);
    resetn = 1'b1;
    e_chg = strap;
    e_ovr = 1'b0;
    e_rem = 4'h0;
    e_used = 4'hF;
    e_lso = 4'h0;
    repeat (6) @(posedge sys_clk);
    check_all();
    do_wr(8'h06, 8'h0F);
    do_wr(8'h08, 8'h03);
    do_lso(4'h9);
    check_all();
    do_wr(8'h07, 8'h80);
    check_all();
    do_wr(8'h07, 8'h0A);
    check_all();
    // override taken from clear in the same write as the removable value
    do_wr(8'h07, 8'h85);
    do_wr(8'h08, 8'h03);
    do_lso(4'h6);
    check_all();
    // mid-run reset: straps taken again, stored used back to all set
    @(posedge sys_clk);
    #1;
    resetn = 1'b0;
    strap = ~strap;
    repeat (2) @(posedge sys_clk);
    #1;
    cmp4("port_used", 4'hF, used);
    cmp4("charge_port_enable", 4'h0, chg);
    resetn = 1'b1;
    e_chg = strap;
    e_ovr = 1'b0;
    e_rem = 4'h0;
    e_used = 4'hF;
    e_lso = 4'h0;
    repeat (6) @(posedge sys_clk);
    do_wr(8'h07, 8'h80);
    check_all();
    for (int k = 0; k < 150; k++) begin
      r = $random(seed);
      otp_nr = r[3:0];
      otp_used = r[7:4];
      otp_lso = r[11:8];
      sbm = r[12];
      repeat (3) @(posedge sys_clk);
      r = $random(seed);
      do_wr(8'h06 + {6'h00, r[9:8]}, r[7:0]);
      if (r[10]) do_lso(r[15:12]);
      check_all();
    end
    final_report();
  end
endmodule
